// ===== pbs_core_model.sv
// Core fetch model driving fetch requests at the program counter
`timescale 1ns/100ps
module pbs_core_model (
  // Clock and commands
  input  wire logic        clk_sys_i,
  input  wire logic        go_i,
  input  wire logic [15:0] pc_i,
  // Fetch side
  output logic             fetch_req_o,
  output logic [15:0]      fetch_addr_o
);
  logic [15:0] last_r = 16'h0;
  always @(posedge clk_sys_i) begin
    last_r <= fetch_addr_o;
  end
  // Idle address is the inverse of the previous cycle's address, so it repeats the last fetch address every second idle cycle
  assign fetch_req_o  = go_i;
  assign fetch_addr_o = go_i ? pc_i : ~last_r;
endmodule

// ===== pbs_mem.sv
// Byte-wide flash array model with registered read data
`timescale 1ns/100ps
module pbs_mem #(
  parameter int unsigned DEPTH = 8192,
  parameter int unsigned AW    = 13
) (
  // Clock and reset
  input  wire logic clk_sys_i,
  input  wire logic arst_n_i,
  // Access channel
  pbs_mem_if.mem    port
);

  logic [7:0] array_r [DEPTH];
  logic [7:0] rdata_r;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // No reset on the array: program writes are the content's only master
  always_ff @(posedge clk_sys_i) begin
    if (port.en && port.we) begin
      array_r[port.addr] <= port.wdata;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_r <= 8'h00;
    end else if (port.en && !port.we) begin
      rdata_r <= array_r[port.addr];
    end
  end

  assign port.rdata = rdata_r;

endmodule

// ===== pbs_mem_if.sv
// Access channel between the switching logic and one flash array
`timescale 1ns/100ps
interface pbs_mem_if #(
  parameter int unsigned AW = 16
);
  logic          en;
  logic          we;
  logic [AW-1:0] addr;
  logic [7:0]    wdata;
  logic [7:0]    rdata;

  modport ctrl (output en, output we, output addr, output wdata, input rdata);
  modport mem  (input en, input we, input addr, input wdata, output rdata);
endinterface

// ===== pbs_pkg.sv
// Shared constants and types for program block switching
package pbs_pkg;

  // ----------------------------------------------------------------
  // Flash geometry
  // ----------------------------------------------------------------
  localparam int unsigned PRI_BYTES    = 65536;
  localparam int unsigned SEC_BYTES    = 8192;
  localparam int unsigned SECTOR_BYTES = 128;
  localparam int unsigned PRI_SECTORS  = 512;
  localparam int unsigned SEC_SECTORS  = 64;
  localparam int unsigned OFS_W        = 7;
  localparam int unsigned ADDR_W       = 16;
  localparam int unsigned PRI_SEC_W    = 9;
  localparam int unsigned SEC_SEC_W    = 6;
  localparam int unsigned DATA_W       = 8;

  // ----------------------------------------------------------------
  // Overlay window and select values
  // ----------------------------------------------------------------
  localparam logic [15:0] OVL_LIMIT      = 16'h2000;
  localparam logic [1:0]  SEL_OVERLAY    = 2'h0;
  localparam logic [1:0]  SEL_RST_POR    = 2'h0;
  localparam logic [1:0]  SEL_RST_SOFT   = 2'h2;
  localparam logic        CFG_PROGRAMMED = 1'b0;
  localparam logic        CFG_RST_VALUE  = 1'b1;

  // ----------------------------------------------------------------
  // Reset causes and config write sources
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CAUSE_POR_EXT = 2'b00,
    CAUSE_WDT_BOD = 2'b01,
    CAUSE_SOFT    = 2'b10
  } pbs_cause_e;

  typedef enum logic [1:0] {
    SRC_NONE = 2'b00,
    SRC_HOST = 2'b01,
    SRC_IAP  = 2'b10
  } pbs_src_e;

endpackage

// ===== pbs_switch.sv
// Program flash block switching: overlay of secondary block on low 8 KByte
//
// Contract
// R1 - Two flash blocks: 64K primary, 8K secondary
// R2 - Fetch space 64K; select field picks low block
// R3 - Primary block is 512 sectors of 128 bytes
// R4 - Secondary block is 64 sectors of 128 bytes
// R5 - Low 7 bits byte, upper bits sector
// R6 - Select 01/10/11: secondary only via in-app programming
// R7 - Select 00: fetch below 2000H from secondary
// R8 - Overlay: fetch above window from primary
// R9 - Overlay: primary low 8K reachable via in-app programming
// R10 - Select field set from startup bit and reset
// R11 - Power-on/pin reset: 00 unprogrammed, 01 programmed
// R12 - Watchdog/brown-out: bit0 from startup bit, bit1 kept
// R13 - Software reset: 10 unprogrammed, 11 programmed
// R14 - Startup bit reads 0 programmed, 1 unprogrammed
// R15 - Startup bit written only by host/in-app commands
// R16 - Software may rewrite bit0 any time after reset
// R17 - Bit0 write never changes startup bit
// R18 - Software avoids switching while executing in low window
// R19 - Select change applies from next fetch, atomically
`timescale 1ns/100ps
module pbs_switch #(
  parameter int unsigned PRI_DEPTH = pbs_pkg::PRI_BYTES,
  parameter int unsigned SEC_DEPTH = pbs_pkg::SEC_BYTES
) (
  // Clock and power-on reset
  input  wire logic                     clk_sys_i,
  input  wire logic                     arst_n_i,
  // Other device resets, held while active
  input  wire logic                     sys_rst_i,
  input  wire logic [1:0]               rst_cause_i,
  // Instruction fetch
  input  wire logic                     fetch_req_i,
  input  wire logic [15:0]              fetch_addr_i,
  output logic                          fetch_valid_o,
  output logic [7:0]                    fetch_data_o,
  output logic                          fetch_from_sec_o,
  // In-application programming access
  input  wire logic                     iap_req_i,
  input  wire logic                     iap_we_i,
  input  wire logic                     iap_blk_i,
  input  wire logic [15:0]              iap_addr_i,
  input  wire logic [7:0]               iap_wdata_i,
  output logic                          iap_ready_o,
  output logic                          iap_valid_o,
  output logic                          iap_err_o,
  output logic [7:0]                    iap_rdata_o,
  // Software access to bank select bit 0
  input  wire logic                     sel_wr_i,
  input  wire logic                     sel_bit0_i,
  output logic [1:0]                    bank_select_field_o,
  // Startup configuration bit commands
  input  wire logic                     cfg_wr_i,
  input  wire logic [1:0]               cfg_src_i,
  input  wire logic                     cfg_val_i,
  output logic                          startup_config_bit_o
);

  localparam int unsigned PRI_AW = pbs_pkg::PRI_SEC_W + pbs_pkg::OFS_W;
  localparam int unsigned SEC_AW = pbs_pkg::SEC_SEC_W + pbs_pkg::OFS_W;

  logic [1:0]  bank_select_field_r;
  logic        startup_config_bit_r;
  logic        init_pend_r;
  logic [1:0]  cause_r;
  logic        fetch_valid_r;
  logic        fetch_sec_r;
  logic        iap_valid_r;
  logic        iap_err_r;
  logic        iap_sec_r;
  logic        iap_err_nxt;
  logic        fetch_sec_nxt;
  logic        iap_go;
  logic        cfg_ok;
  logic        sel_ok;
  logic [1:0]  field_nxt;

  // ----------------------------------------------------------------
  // Address decomposition
  // ----------------------------------------------------------------
  // R5 sector and byte fields
  logic [pbs_pkg::OFS_W-1:0]     f_ofs;
  logic [pbs_pkg::PRI_SEC_W-1:0] f_pri_sec;
  logic [pbs_pkg::SEC_SEC_W-1:0] f_sec_sec;
  logic [pbs_pkg::OFS_W-1:0]     i_ofs;
  logic [pbs_pkg::PRI_SEC_W-1:0] i_pri_sec;
  logic [pbs_pkg::SEC_SEC_W-1:0] i_sec_sec;

  assign f_ofs     = fetch_addr_i[pbs_pkg::OFS_W-1:0];
  assign f_pri_sec = fetch_addr_i[15:pbs_pkg::OFS_W];
  assign f_sec_sec = fetch_addr_i[SEC_AW-1:pbs_pkg::OFS_W];
  assign i_ofs     = iap_addr_i[pbs_pkg::OFS_W-1:0];
  assign i_pri_sec = iap_addr_i[15:pbs_pkg::OFS_W];
  assign i_sec_sec = iap_addr_i[SEC_AW-1:pbs_pkg::OFS_W];

  // ----------------------------------------------------------------
  // Flash arrays
  // ----------------------------------------------------------------
  pbs_mem_if #(.AW(PRI_AW)) pri_if ();
  pbs_mem_if #(.AW(SEC_AW)) sec_if ();

  // R1 two physical blocks, R3 R4 sector counts
  pbs_mem #(
    .DEPTH (PRI_DEPTH),
    .AW    (PRI_AW)
  ) u_pri (
    .clk_sys_i (clk_sys_i),
    .arst_n_i  (arst_n_i),
    .port      (pri_if.mem)
  );

  pbs_mem #(
    .DEPTH (SEC_DEPTH),
    .AW    (SEC_AW)
  ) u_sec (
    .clk_sys_i (clk_sys_i),
    .arst_n_i  (arst_n_i),
    .port      (sec_if.mem)
  );

  // ----------------------------------------------------------------
  // Routing
  // ----------------------------------------------------------------
  // Fetch owns the arrays in its cycle; programming waits for a cycle with no fetch
  // A fetch in every cycle starves programming; the core must leave gaps
  assign iap_ready_o = !fetch_req_i && !init_pend_r;
  assign iap_go      = iap_req_i && iap_ready_o;

  always_comb begin
    // R7 R8 overlay decode, R6 no overlay otherwise
    fetch_sec_nxt = (bank_select_field_r == pbs_pkg::SEL_OVERLAY) &&
                    (fetch_addr_i < pbs_pkg::OVL_LIMIT);
    // R6 R9 in-app reach of the low window only for secondary
    iap_err_nxt   = iap_blk_i && (iap_addr_i >= pbs_pkg::OVL_LIMIT);
  end

  always_comb begin
    pri_if.en    = 1'b0;
    pri_if.we    = 1'b0;
    pri_if.addr  = {f_pri_sec, f_ofs};
    pri_if.wdata = iap_wdata_i;
    sec_if.en    = 1'b0;
    sec_if.we    = 1'b0;
    sec_if.addr  = {f_sec_sec, f_ofs};
    sec_if.wdata = iap_wdata_i;
    // R2 one 64K fetch space
    if (fetch_req_i && !init_pend_r) begin
      pri_if.en = !fetch_sec_nxt;
      sec_if.en = fetch_sec_nxt;
    end else if (iap_go && !iap_err_nxt) begin
      // R9 primary low window via in-app path regardless of select
      if (iap_blk_i) begin
        sec_if.en   = 1'b1;
        sec_if.we   = iap_we_i;
        sec_if.addr = {i_sec_sec, i_ofs};
      end else begin
        pri_if.en   = 1'b1;
        pri_if.we   = iap_we_i;
        pri_if.addr = {i_pri_sec, i_ofs};
      end
    end
  end

  // ----------------------------------------------------------------
  // Fetch answer
  // ----------------------------------------------------------------
  // R2 one answer per fetch
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fetch_valid_r <= 1'b0;
    end else begin
      fetch_valid_r <= fetch_req_i && !init_pend_r;
    end
  end

  // R19 block choice frozen with the request, no mixed mapping
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fetch_sec_r <= 1'b0;
    end else if (fetch_req_i) begin
      fetch_sec_r <= fetch_sec_nxt;
    end
  end

  assign fetch_valid_o    = fetch_valid_r;
  assign fetch_from_sec_o = fetch_sec_r;
  assign fetch_data_o     = fetch_sec_r ? sec_if.rdata : pri_if.rdata;

  // ----------------------------------------------------------------
  // Programming answer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      iap_valid_r <= 1'b0;
    end else begin
      iap_valid_r <= iap_go;
    end
  end

  // An out-of-range secondary access is answered, never dropped
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      iap_err_r <= 1'b0;
    end else begin
      iap_err_r <= iap_go && iap_err_nxt;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      iap_sec_r <= 1'b0;
    end else if (iap_go) begin
      iap_sec_r <= iap_blk_i;
    end
  end

  assign iap_valid_o = iap_valid_r;
  assign iap_err_o   = iap_err_r;
  assign iap_rdata_o = iap_err_r ? 8'h00 : (iap_sec_r ? sec_if.rdata : pri_if.rdata);

  // ----------------------------------------------------------------
  // Startup configuration bit
  // ----------------------------------------------------------------
  // R15 only host or in-app commands may write it
  assign cfg_ok = cfg_wr_i && ((cfg_src_i == pbs_pkg::SRC_HOST) ||
                               (cfg_src_i == pbs_pkg::SRC_IAP));

  // Power-on stands for an erased part; true nonvolatile keep is not modelled
  // R14 stored as read: 0 programmed, 1 unprogrammed
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      startup_config_bit_r <= pbs_pkg::CFG_RST_VALUE;
    end else if (cfg_ok) begin
      startup_config_bit_r <= cfg_val_i;
    end
  end

  assign startup_config_bit_o = startup_config_bit_r;

  // ----------------------------------------------------------------
  // Reset cause capture
  // ----------------------------------------------------------------
  // Cause is sampled while reset is held, never under the async reset
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      init_pend_r <= 1'b1;
    end else if (sys_rst_i) begin
      init_pend_r <= 1'b1;
    end else begin
      init_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cause_r <= pbs_pkg::CAUSE_POR_EXT;
    end else if (sys_rst_i) begin
      cause_r <= rst_cause_i;
    end
  end

  // ----------------------------------------------------------------
  // Bank select field
  // ----------------------------------------------------------------
  logic prog;
  assign prog = (startup_config_bit_r == pbs_pkg::CFG_PROGRAMMED);

  always_comb begin
    field_nxt = bank_select_field_r;
    unique case (cause_r)
      // R11 power-on or pin reset
      pbs_pkg::CAUSE_POR_EXT: field_nxt = pbs_pkg::SEL_RST_POR | {1'b0, prog};
      // R12 bit1 survives
      pbs_pkg::CAUSE_WDT_BOD: field_nxt = {bank_select_field_r[1], prog};
      // R13 software reset
      pbs_pkg::CAUSE_SOFT:    field_nxt = pbs_pkg::SEL_RST_SOFT | {1'b0, prog};
      default:                field_nxt = pbs_pkg::SEL_RST_POR | {1'b0, prog};
    endcase
  end

  // Software must not flip bit 0 while running from the low window
  // R16 R17 bit0 only, startup bit untouched
  assign sel_ok = sel_wr_i && !init_pend_r && !sys_rst_i;

  // R10 loaded on the first edge after reset release
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bank_select_field_r <= pbs_pkg::SEL_RST_POR;
    end else if (init_pend_r && !sys_rst_i) begin
      bank_select_field_r <= field_nxt;
    end else if (sel_ok) begin
      bank_select_field_r[0] <= sel_bit0_i;
    end
  end

  assign bank_select_field_o = bank_select_field_r;

endmodule

// ===== pbs_switch_monitor.sv
// Port checker for program block switching
`timescale 1ns/100ps
module pbs_switch_monitor (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        arst_n_i,
  // Watched ports
  input  wire logic        sys_rst_i,
  input  wire logic [1:0]  rst_cause_i,
  input  wire logic        fetch_req_i,
  input  wire logic [15:0] fetch_addr_i,
  input  wire logic        fetch_valid_o,
  input  wire logic        fetch_from_sec_o,
  input  wire logic        iap_req_i,
  input  wire logic        iap_blk_i,
  input  wire logic [15:0] iap_addr_i,
  input  wire logic        iap_ready_o,
  input  wire logic        iap_valid_o,
  input  wire logic        iap_err_o,
  input  wire logic        sel_wr_i,
  input  wire logic        sel_bit0_i,
  input  wire logic [1:0]  bank_select_field_o,
  input  wire logic        cfg_wr_i,
  input  wire logic [1:0]  cfg_src_i,
  input  wire logic        cfg_val_i,
  input  wire logic        startup_config_bit_o
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  logic ok_r;
  logic acc;
  logic want_sec;
  logic bad_iap;
  logic cfg_cmd;
  // Requests count only one edge after init or a device reset
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ok_r <= 1'b0;
    end else begin
      ok_r <= !sys_rst_i;
    end
  end
  assign acc      = ok_r && !sys_rst_i;
  assign want_sec = bank_select_field_o == 2'h0 && fetch_addr_i < 16'h2000;
  assign bad_iap  = iap_blk_i && iap_addr_i >= 16'h2000;
  assign cfg_cmd  = cfg_wr_i && (cfg_src_i == 2'h1 || cfg_src_i == 2'h2);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_exit(logic [1:0] c);
    sys_rst_i && rst_cause_i == c ##1 !sys_rst_i;
  endsequence
  chk_fetch_map:
    assert property (acc && fetch_req_i |=> fetch_valid_o && fetch_from_sec_o == $past(want_sec))
    else $error("fetch answer or block wrong");
  chk_fetch_idle:
    assert property (!(acc && fetch_req_i) |=> !fetch_valid_o)
    else $error("fetch answer without request");
  chk_iap_answer:
    assert property (acc && iap_req_i && iap_ready_o |=> iap_valid_o && iap_err_o == $past(bad_iap))
    else $error("in-app answer wrong");
  chk_iap_idle:
    assert property (!iap_req_i |=> !iap_valid_o)
    else $error("in-app answer without request");
  chk_sel_write:
    assert property (acc && sel_wr_i |=> bank_select_field_o[0] == $past(sel_bit0_i)
                     && $stable(bank_select_field_o[1]))
    else $error("select write not followed");
  chk_por_load:
    assert property (s_exit(2'h0) |=> bank_select_field_o == {1'b0, !$past(startup_config_bit_o)})
    else $error("power-on field wrong");
  chk_wdt_load:
    assert property (s_exit(2'h1) |=> bank_select_field_o ==
                     {$past(bank_select_field_o[1]), !$past(startup_config_bit_o)})
    else $error("watchdog field wrong");
  chk_soft_load:
    assert property (s_exit(2'h2) |=> bank_select_field_o == {1'b1, !$past(startup_config_bit_o)})
    else $error("software reset field wrong");
  chk_cfg_write:
    assert property (cfg_cmd |=> startup_config_bit_o == $past(cfg_val_i))
    else $error("startup bit write lost");
  chk_cfg_keep:
    assert property (!cfg_cmd |=> $stable(startup_config_bit_o))
    else $error("startup bit changed");
  chk_ready_block:
    assert property (fetch_req_i |-> !iap_ready_o)
    else $error("in-app ready during fetch");
endmodule
bind pbs_switch pbs_switch_monitor pbs_switch_monitor_inst (.*);

// ===== testbench.sv
// Self-checking bench for program block switching
`timescale 1ns/100ps
module testbench;
  logic        clk_sys_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic        sys_rst_i = 1'b0;
  logic [1:0]  rst_cause_i = 2'h0;
  logic        go = 1'b0;
  logic [15:0] pc = 16'h0;
  logic        fetch_req, fetch_valid, fetch_sec, iap_ready, iap_valid, iap_err, cfg_bit;
  logic [15:0] fetch_addr, a;
  logic [7:0]  fetch_data, iap_rdata, d;
  logic        iap_req = 1'b0, iap_we = 1'b0, iap_blk = 1'b0;
  logic [15:0] iap_addr = 16'h0;
  logic [7:0]  iap_wdata = 8'h0;
  logic        sel_wr = 1'b0, sel_bit0 = 1'b0, cfg_wr = 1'b0, cfg_val = 1'b0, cfg = 1'b1;
  logic [1:0]  field, cfg_src = 2'h0, fld = 2'h0;
  logic [31:0] seed = 32'h3c, r;
  logic [7:0]  pri_m [65536];
  logic [7:0]  sec_m [8192];
  int          miscompares = 0, num_checks = 0, cycles = 0;
  pbs_switch pbs_switch_inst (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .sys_rst_i(sys_rst_i),
    .rst_cause_i(rst_cause_i), .fetch_req_i(fetch_req), .fetch_addr_i(fetch_addr),
    .fetch_valid_o(fetch_valid), .fetch_data_o(fetch_data), .fetch_from_sec_o(fetch_sec),
    .iap_req_i(iap_req), .iap_we_i(iap_we), .iap_blk_i(iap_blk), .iap_addr_i(iap_addr),
    .iap_wdata_i(iap_wdata), .iap_ready_o(iap_ready), .iap_valid_o(iap_valid),
    .iap_err_o(iap_err), .iap_rdata_o(iap_rdata), .sel_wr_i(sel_wr), .sel_bit0_i(sel_bit0),
    .bank_select_field_o(field), .cfg_wr_i(cfg_wr), .cfg_src_i(cfg_src), .cfg_val_i(cfg_val),
    .startup_config_bit_o(cfg_bit));
  pbs_core_model pbs_core_model_inst (.clk_sys_i(clk_sys_i), .go_i(go), .pc_i(pc),
    .fetch_req_o(fetch_req), .fetch_addr_o(fetch_addr));
  initial begin
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      test_done();
    end
  end
  // ----------------------------------------
  // Expectations and bus tasks
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [1:0] exp_field(input logic [1:0] c, input logic v, input logic [1:0] o);
    return {c == 2'h1 ? o[1] : c == 2'h2, ~v};
  endfunction
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic in_app_programming(input logic we, input logic blk, input logic [15:0] ad, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    iap_req <= 1'b1;
    iap_we <= we;
    iap_blk <= blk;
    iap_addr <= ad;
    iap_wdata <= wd;
    @(posedge clk_sys_i);
    while (iap_ready !== 1'b1 && n < 20) begin
      @(posedge clk_sys_i);
      n++;
    end
    iap_req <= 1'b0;
    #1;
    chk("iap valid", {15'h0, iap_valid}, 16'h1);
  endtask
  task automatic fetch(input logic [15:0] ad);
    logic s;
    s = fld == 2'h0 && ad < 16'h2000;
    @(posedge clk_sys_i);
    go <= 1'b1;
    pc <= ad;
    @(posedge clk_sys_i);
    go <= 1'b0;
    #1;
    chk("fetch valid", {15'h0, fetch_valid}, 16'h1);
    chk("fetch block", {15'h0, fetch_sec}, {15'h0, s});
    chk("fetch data", {8'h0, fetch_data}, {8'h0, s ? sec_m[ad[12:0]] : pri_m[ad]});
  endtask
  task automatic sel(input logic b);
    @(posedge clk_sys_i);
    sel_wr <= 1'b1;
    sel_bit0 <= b;
    @(posedge clk_sys_i);
    sel_wr <= 1'b0;
    fld[0] = b;
    #1;
    chk("select field", {14'h0, field}, {14'h0, fld});
    chk("startup bit", {15'h0, cfg_bit}, {15'h0, cfg});
  endtask
  task automatic cfgw(input logic [1:0] src, input logic v);
    @(posedge clk_sys_i);
    cfg_wr <= 1'b1;
    cfg_src <= src;
    cfg_val <= v;
    @(posedge clk_sys_i);
    cfg_wr <= 1'b0;
    if (src == 2'h1 || src == 2'h2) cfg = v;
    #1;
    chk("startup bit", {15'h0, cfg_bit}, {15'h0, cfg});
  endtask
  task automatic rst(input logic [1:0] c);
    @(posedge clk_sys_i);
    sys_rst_i <= 1'b1;
    rst_cause_i <= c;
    repeat (2) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_sys_i);
    fld = exp_field(c, cfg, fld);
    #1;
    chk("reset field", {14'h0, field}, {14'h0, fld});
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    #1;
    chk("power-on field", {14'h0, field}, 16'h0);
    chk("power-on startup", {15'h0, cfg_bit}, 16'h1);
    $display("test reset_values done");
    for (int i = 0; i < 40; i++) begin
      r = rnd();
      a = i == 0 ? 16'h0 : i == 1 ? 16'h1fff : i == 2 ? 16'h2000 : i == 3 ? 16'hffff : r[15:0];
      d = r[23:16];
      pri_m[a] = d;
      in_app_programming(1'b1, 1'b0, a, d);
      if (a < 16'h2000) begin
        sec_m[a[12:0]] = ~d;
        in_app_programming(1'b1, 1'b1, a, ~d);
        in_app_programming(1'b0, 1'b1, a, 8'h0);
        chk("secondary readback", {8'h0, iap_rdata}, {8'h0, ~d});
      end
      // Switch only between fetches, whichever window the last fetch was in
      if (r[31]) sel(r[30]);
      fetch(a);
      in_app_programming(1'b0, 1'b0, a, 8'h0);
      chk("primary readback", {8'h0, iap_rdata}, {8'h0, d});
    end
    in_app_programming(1'b1, 1'b1, 16'h2000, 8'h5a);
    chk("secondary range", {15'h0, iap_err}, 16'h1);
    $display("test block_map done");
    for (int k = 0; k < 8; k++) begin
      cfgw({k[0], k[0]}, k[2]);
      cfgw(k[0] ? 2'h2 : 2'h1, ~k[2]);
      sel(k[1]);
      rst(2'(k * 3));
      fetch(16'h0);
      fetch(16'h1fff);
    end
    $display("test reset_causes done");
    test_done();
  end
endmodule
